// >>> core/dprf_regs.svh
// offsets, bit masks and reset values of the reference profile bank
// assumes byte-wide software access with byte addresses
// Behaviour
// - priority byte bit 7 picks phase threshold unit, 0 ps, 1 ns.
// - phase lock threshold is 16 bits, two bytes, low byte first.
// - selection priority, bits 2:0, ranks the reference at level 0 to 7.
// - promoted priority, bits 5:3, applies only while reference is active.
// - reference period is 40 bits of fs over five bytes, low first.
// - tolerances are 20 bits: two bytes plus low nibble of a third.
// - validation timer is 16 bits of ms, low byte first.
// - redetect timer is 16 bits of ms, low byte first.
// - frequency lock threshold is 24 bits of ps, low byte first.
// - each lock detector has its own 8-bit fill and drain rate bytes.
// - loop coefficient is fractional linear part times two to exponent.
// - linear parts are 16, 17, 17 and 15 bits, some split over bytes.
// - exponents are 6, 3, 4, 5, 5 and 5 bits, several split.
// - input divider is 30 bits and divides by value plus one.
// - fraction divider holds two 10-bit terms packed into three bytes.
// - second profile spans 0x0632 to 0x067f, input divider at 0x0650.
`ifndef DPRF_REGS_SVH
`define DPRF_REGS_SVH

`define DPRF_BASE 16'h0626
`define DPRF_LAST 16'h0653
`define DPRF_NBYTES 46
`define DPRF_I(a) ((a) - `DPRF_BASE)

`define DPRF_FRAC_P0 16'h0626
`define DPRF_PHTHR_P0 16'h0629
`define DPRF_PHFILL_P0 16'h062b
`define DPRF_PHDRAIN_P0 16'h062c
`define DPRF_FQTHR_P0 16'h062d
`define DPRF_FQFILL_P0 16'h0630
`define DPRF_FQDRAIN_P0 16'h0631
`define DPRF_PRIO_P1 16'h0632
`define DPRF_PERIOD_P1 16'h0633
`define DPRF_PAD_P1 16'h0638
`define DPRF_INTOL_P1 16'h063a
`define DPRF_OUTTOL_P1 16'h063d
`define DPRF_VALTMR_P1 16'h0640
`define DPRF_REDTMR_P1 16'h0642
`define DPRF_LOOP_P1 16'h0644
`define DPRF_RDIV_P1 16'h0650
`define DPRF_P1_FIRST 16'h0632
`define DPRF_P1_LAST 16'h067f
`define DPRF_STATUS 16'h067e

`define DPRF_PRIO_SCALE 7
`define DPRF_MASK_PRIO 8'hbf
`define DPRF_MASK_FRAC_MID 8'hf3
`define DPRF_MASK_LOW6 8'h3f
`define DPRF_MASK_NIB 8'h0f
`define DPRF_MASK_LOW7 8'h7f
`define DPRF_MASK_FULL 8'hff
`define DPRF_MASK_NONE 8'h00
`define DPRF_RESET_BYTE 8'h00
`define DPRF_NS_TO_PS 26'h00003e8

`endif

// >>> core/dprf_pkg.sv
// types of the reference profile bank
// assumes the offsets header is included by the users of these types
`default_nettype none
package dprf_pkg;
  typedef logic [7:0] dprf_byte_t;
  typedef struct packed {
    logic [45:0][7:0] mem;
    logic [7:0] rdata;
    logic [30:0] r_ratio;
    logic [25:0] ph_thr_ps;
    logic [2:0] eff_prio;
    logic prio_err;
  } dprf_state_s;
endpackage
`default_nettype wire

// >>> core/dprf_regs_top.sv
// byte register bank for profile settings of the clock synchroniser
// assumes a single-cycle strobe master on mclk that never waits
`timescale 1ns/1ps
`default_nettype none
`include "dprf_regs.svh"

module dprf_regs_top
  import dprf_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  // context from the rest of the device
  input wire logic p0_phase_scale,
  input wire logic p1_ref_active,
  // profile 0 tail
  output logic [9:0] p0_frac_v,
  output logic [9:0] p0_frac_u,
  output logic [15:0] p0_phase_thr,
  output logic [25:0] p0_phase_thr_ps,
  output logic [7:0] p0_phase_fill,
  output logic [7:0] p0_phase_drain,
  output logic [23:0] p0_freq_thr,
  output logic [7:0] p0_freq_fill,
  output logic [7:0] p0_freq_drain,
  // profile 1 priorities and reference window
  output logic p1_phase_scale,
  output logic [2:0] p1_sel_prio,
  output logic [2:0] p1_prom_prio,
  output logic [2:0] p1_eff_prio,
  output logic p1_prio_err,
  output logic [39:0] p1_ref_period,
  output logic [19:0] p1_inner_tol,
  output logic [19:0] p1_outer_tol,
  output logic [15:0] p1_valid_timer,
  output logic [15:0] p1_redet_timer,
  // profile 1 loop filter
  output logic [15:0] p1_alpha0_lin,
  output logic [5:0] p1_alpha1_exp,
  output logic [2:0] p1_alpha2_exp,
  output logic [3:0] p1_alpha3_exp,
  output logic [16:0] p1_beta0_lin,
  output logic [4:0] p1_beta1_exp,
  output logic [16:0] p1_gamma0_lin,
  output logic [4:0] p1_gamma1_exp,
  output logic [14:0] p1_delta0_lin,
  output logic [4:0] p1_delta1_exp,
  // profile 1 input divider
  output logic [29:0] p1_rdiv,
  output logic [30:0] p1_rdiv_ratio
);

  ////////////////////////////////////////////////////////////////////////////
  // bit masks per byte address

  // one table serves both write masking and read masking
  function automatic dprf_byte_t byte_mask(input logic [15:0] a);
    if (a < `DPRF_BASE || a > `DPRF_LAST) begin
      return `DPRF_MASK_NONE;
    end
    unique case (a)
      16'h0627: return `DPRF_MASK_FRAC_MID;
      16'h0628: return `DPRF_MASK_LOW6;
      16'h0632: return `DPRF_MASK_PRIO;
      16'h0638, 16'h0639: return `DPRF_MASK_NONE;
      16'h063c, 16'h063f: return `DPRF_MASK_NIB;
      16'h0649: return `DPRF_MASK_LOW7;
      16'h064c: return `DPRF_MASK_LOW6;
      16'h0653: return `DPRF_MASK_LOW6;
      default: return `DPRF_MASK_FULL;
    endcase
  endfunction

  function automatic logic [5:0] byte_index(input logic [15:0] a);
    logic [15:0] d;
    d = `DPRF_I(a);
    return d[5:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  dprf_state_s s_q;
  dprf_state_s s_d;
  logic [45:0][7:0] m;
  logic [7:0] status_byte;
  logic [29:0] rdiv_d;
  logic [15:0] phthr_d;
  logic [2:0] sel_d;
  logic [2:0] prom_d;

  assign m = s_q.mem;
  // status is read only and reports the priority in force
  assign status_byte = {4'h0, s_q.eff_prio, s_q.prio_err};

  always_comb begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    rdiv_d = 30'h00000000;
    phthr_d = 16'h0000;
    sel_d = 3'h0;
    prom_d = 3'h0;
    if (wr_stb && byte_mask(addr) != `DPRF_MASK_NONE) begin
      // unused bits are dropped on write so they read as zero
      s_d.mem[byte_index(addr)] = wdata & byte_mask(addr);
    end
    if (rd_stb) begin
      if (addr == `DPRF_STATUS) begin
        s_d.rdata = status_byte;
      end else begin
        s_d.rdata = s_q.mem[byte_index(addr)] & byte_mask(addr);
      end
    end
    rdiv_d = {s_d.mem[`DPRF_I(16'h0653)][5:0],
              s_d.mem[`DPRF_I(16'h0652)],
              s_d.mem[`DPRF_I(16'h0651)],
              s_d.mem[`DPRF_I(16'h0650)]};
    s_d.r_ratio = {1'b0, rdiv_d} + 31'h00000001;
    phthr_d = {s_d.mem[`DPRF_I(16'h062a)], s_d.mem[`DPRF_I(16'h0629)]};
    // ns threshold widened so it never wraps when turned into ps
    s_d.ph_thr_ps = p0_phase_scale ?
      26'(phthr_d * `DPRF_NS_TO_PS) : {10'h000, phthr_d};
    sel_d = s_d.mem[`DPRF_I(`DPRF_PRIO_P1)][2:0];
    prom_d = s_d.mem[`DPRF_I(`DPRF_PRIO_P1)][5:3];
    s_d.eff_prio = p1_ref_active ? prom_d : sel_d;
    // flag only; the ordering is the software's duty
    s_d.prio_err = prom_d > sel_d;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field views

  assign rdata = s_q.rdata;

  assign p0_frac_v = {m[`DPRF_I(16'h0627)][1:0], m[`DPRF_I(16'h0626)]};
  assign p0_frac_u = {m[`DPRF_I(16'h0628)][5:0],
                      m[`DPRF_I(16'h0627)][7:4]};
  assign p0_phase_thr = {m[`DPRF_I(16'h062a)], m[`DPRF_I(16'h0629)]};
  assign p0_phase_thr_ps = s_q.ph_thr_ps;
  assign p0_phase_fill = m[`DPRF_I(`DPRF_PHFILL_P0)];
  assign p0_phase_drain = m[`DPRF_I(`DPRF_PHDRAIN_P0)];
  assign p0_freq_thr = {m[`DPRF_I(16'h062f)], m[`DPRF_I(16'h062e)],
                        m[`DPRF_I(16'h062d)]};
  assign p0_freq_fill = m[`DPRF_I(`DPRF_FQFILL_P0)];
  assign p0_freq_drain = m[`DPRF_I(`DPRF_FQDRAIN_P0)];

  assign p1_phase_scale = m[`DPRF_I(`DPRF_PRIO_P1)][`DPRF_PRIO_SCALE];
  assign p1_sel_prio = m[`DPRF_I(`DPRF_PRIO_P1)][2:0];
  assign p1_prom_prio = m[`DPRF_I(`DPRF_PRIO_P1)][5:3];
  assign p1_eff_prio = s_q.eff_prio;
  assign p1_prio_err = s_q.prio_err;
  assign p1_ref_period = {m[`DPRF_I(16'h0637)], m[`DPRF_I(16'h0636)],
                          m[`DPRF_I(16'h0635)], m[`DPRF_I(16'h0634)],
                          m[`DPRF_I(16'h0633)]};
  assign p1_inner_tol = {m[`DPRF_I(16'h063c)][3:0], m[`DPRF_I(16'h063b)],
                         m[`DPRF_I(16'h063a)]};
  assign p1_outer_tol = {m[`DPRF_I(16'h063f)][3:0], m[`DPRF_I(16'h063e)],
                         m[`DPRF_I(16'h063d)]};
  assign p1_valid_timer = {m[`DPRF_I(16'h0641)], m[`DPRF_I(16'h0640)]};
  assign p1_redet_timer = {m[`DPRF_I(16'h0643)], m[`DPRF_I(16'h0642)]};

  // linear parts are fractions below one; exponents are plain integers
  assign p1_alpha0_lin = {m[`DPRF_I(16'h0645)], m[`DPRF_I(16'h0644)]};
  assign p1_alpha1_exp = m[`DPRF_I(16'h0646)][5:0];
  assign p1_alpha2_exp = {m[`DPRF_I(16'h0647)][0],
                          m[`DPRF_I(16'h0646)][7:6]};
  assign p1_alpha3_exp = m[`DPRF_I(16'h064f)][7:4];
  assign p1_beta0_lin = {m[`DPRF_I(16'h0649)][1:0], m[`DPRF_I(16'h0648)],
                         m[`DPRF_I(16'h0647)][7:1]};
  assign p1_beta1_exp = m[`DPRF_I(16'h0649)][6:2];
  assign p1_gamma0_lin = {m[`DPRF_I(16'h064c)][0], m[`DPRF_I(16'h064b)],
                          m[`DPRF_I(16'h064a)]};
  assign p1_gamma1_exp = m[`DPRF_I(16'h064c)][5:1];
  assign p1_delta0_lin = {m[`DPRF_I(16'h064e)][6:0],
                          m[`DPRF_I(16'h064d)]};
  assign p1_delta1_exp = {m[`DPRF_I(16'h064f)][3:0],
                          m[`DPRF_I(16'h064e)][7]};
  assign p1_rdiv = {m[`DPRF_I(16'h0653)][5:0], m[`DPRF_I(16'h0652)],
                    m[`DPRF_I(16'h0651)], m[`DPRF_I(16'h0650)]};
  assign p1_rdiv_ratio = s_q.r_ratio;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  AST_RDATA_ONLY_AFTER_READ: assert property (
    !$past(rd_stb) |-> rdata == 8'h00)
    else $error("read data present without a read");

  AST_UNUSED_BITS_ZERO: assert property (
    $past(rd_stb) && $past(addr) != `DPRF_STATUS |->
      (rdata & ~byte_mask($past(addr))) == 8'h00)
    else $error("unused bits read back nonzero");

  AST_WRITE_READBACK: assert property (
    wr_stb && byte_mask(addr) != `DPRF_MASK_NONE ##1
      rd_stb && addr == $past(addr) && !wr_stb |->
      ##1 rdata == ($past(wdata, 2) & byte_mask($past(addr, 2))))
    else $error("written byte not read back");

  AST_PAD_READS_ZERO: assert property (
    rd_stb && (addr == 16'h0638 || addr == 16'h0639) |=> rdata == 8'h00)
    else $error("pad byte reads nonzero");

  AST_RATIO_PLUS_ONE: assert property (
    $past(rst_b) |-> p1_rdiv_ratio == {1'b0, p1_rdiv} + 31'h00000001)
    else $error("divider ratio is not value plus one");

  AST_PHASE_UNIT: assert property (
    p0_phase_scale && !wr_stb |=>
      p0_phase_thr_ps == 26'(p0_phase_thr * `DPRF_NS_TO_PS))
    else $error("ns threshold not scaled to ps");

  AST_PHASE_PS_PASS: assert property (
    !p0_phase_scale && !wr_stb |=> p0_phase_thr_ps == {10'h000, p0_phase_thr})
    else $error("ps threshold altered");

  AST_EFF_PRIO: assert property (
    !wr_stb |=> p1_eff_prio ==
      ($past(p1_ref_active) ? p1_prom_prio : p1_sel_prio))
    else $error("wrong priority in force");

  AST_PRIO_ORDER_FLAG: assert property (
    !wr_stb |=> p1_prio_err == (p1_prom_prio > p1_sel_prio))
    else $error("priority order flag wrong");

  AST_UNMAPPED_ZERO: assert property (
    rd_stb && (addr < `DPRF_BASE || addr > `DPRF_LAST) &&
      addr != `DPRF_STATUS |=> rdata == 8'h00)
    else $error("unmapped address reads nonzero");

  AST_STATUS_READ: assert property (
    rd_stb && addr == `DPRF_STATUS |=>
      rdata == {4'h0, $past(p1_eff_prio), $past(p1_prio_err)})
    else $error("status byte does not match priority in force");

  ////////////////////////////////////////////////////////////////////////////
  // a write must show in its field view at the very next edge

  AST_WR_FRAC_V_LO: assert property (
    wr_stb && addr == 16'h0626 |=> p0_frac_v[7:0] == $past(wdata))
    else $error("fraction low byte not taken");

  AST_WR_FRAC_MID: assert property (
    wr_stb && addr == 16'h0627 |=>
      {p0_frac_u[3:0], 2'b00, p0_frac_v[9:8]} == ($past(wdata) & 8'hf3))
    else $error("fraction middle byte not taken");

  AST_WR_FRAC_U_HI: assert property (
    wr_stb && addr == 16'h0628 |=>
      {2'b00, p0_frac_u[9:4]} == ($past(wdata) & 8'h3f))
    else $error("fraction top byte not taken");

  AST_WR_PHTHR_LO: assert property (
    wr_stb && addr == 16'h0629 |=> p0_phase_thr[7:0] == $past(wdata))
    else $error("phase threshold low byte not taken");

  AST_WR_PHTHR_HI: assert property (
    wr_stb && addr == 16'h062a |=> p0_phase_thr[15:8] == $past(wdata))
    else $error("phase threshold high byte not taken");

  AST_WR_PHFILL: assert property (
    wr_stb && addr == 16'h062b |=> p0_phase_fill == $past(wdata))
    else $error("phase fill rate not taken");

  AST_WR_PHDRAIN: assert property (
    wr_stb && addr == 16'h062c |=> p0_phase_drain == $past(wdata))
    else $error("phase drain rate not taken");

  AST_WR_FQTHR_LO: assert property (
    wr_stb && addr == 16'h062d |=> p0_freq_thr[7:0] == $past(wdata))
    else $error("frequency threshold low byte not taken");

  AST_WR_FQTHR_HI: assert property (
    wr_stb && addr == 16'h062f |=> p0_freq_thr[23:16] == $past(wdata))
    else $error("frequency threshold top byte not taken");

  AST_WR_FQFILL: assert property (
    wr_stb && addr == 16'h0630 |=> p0_freq_fill == $past(wdata))
    else $error("frequency fill rate not taken");

  AST_WR_FQDRAIN: assert property (
    wr_stb && addr == 16'h0631 |=> p0_freq_drain == $past(wdata))
    else $error("frequency drain rate not taken");

  AST_WR_PRIO: assert property (
    wr_stb && addr == 16'h0632 |=>
      {p1_phase_scale, 1'b0, p1_prom_prio, p1_sel_prio} ==
      ($past(wdata) & 8'hbf))
    else $error("priority byte not taken");

  AST_WR_PERIOD_LO: assert property (
    wr_stb && addr == 16'h0633 |=> p1_ref_period[7:0] == $past(wdata))
    else $error("period low byte not taken");

  AST_WR_PERIOD_HI: assert property (
    wr_stb && addr == 16'h0637 |=> p1_ref_period[39:32] == $past(wdata))
    else $error("period top byte not taken");

  AST_WR_INTOL_LO: assert property (
    wr_stb && addr == 16'h063a |=> p1_inner_tol[7:0] == $past(wdata))
    else $error("inner tolerance low byte not taken");

  AST_WR_INTOL_HI: assert property (
    wr_stb && addr == 16'h063c |=>
      {4'h0, p1_inner_tol[19:16]} == ($past(wdata) & 8'h0f))
    else $error("inner tolerance top nibble not taken");

  AST_WR_OUTTOL_LO: assert property (
    wr_stb && addr == 16'h063d |=> p1_outer_tol[7:0] == $past(wdata))
    else $error("outer tolerance low byte not taken");

  AST_WR_OUTTOL_HI: assert property (
    wr_stb && addr == 16'h063f |=>
      {4'h0, p1_outer_tol[19:16]} == ($past(wdata) & 8'h0f))
    else $error("outer tolerance top nibble not taken");

  AST_WR_VALTMR_LO: assert property (
    wr_stb && addr == 16'h0640 |=> p1_valid_timer[7:0] == $past(wdata))
    else $error("validation timer low byte not taken");

  AST_WR_VALTMR_HI: assert property (
    wr_stb && addr == 16'h0641 |=> p1_valid_timer[15:8] == $past(wdata))
    else $error("validation timer high byte not taken");

  AST_WR_REDTMR_LO: assert property (
    wr_stb && addr == 16'h0642 |=> p1_redet_timer[7:0] == $past(wdata))
    else $error("redetect timer low byte not taken");

  AST_WR_REDTMR_HI: assert property (
    wr_stb && addr == 16'h0643 |=> p1_redet_timer[15:8] == $past(wdata))
    else $error("redetect timer high byte not taken");

  AST_WR_ALPHA_LIN: assert property (
    wr_stb && addr == 16'h0645 |=> p1_alpha0_lin[15:8] == $past(wdata))
    else $error("alpha linear high byte not taken");

  AST_WR_ALPHA_EXP: assert property (
    wr_stb && addr == 16'h0646 |=>
      {p1_alpha2_exp[1:0], p1_alpha1_exp} == $past(wdata))
    else $error("alpha exponent byte not taken");

  AST_WR_BETA_LO: assert property (
    wr_stb && addr == 16'h0647 |=>
      {p1_beta0_lin[6:0], p1_alpha2_exp[2]} == $past(wdata))
    else $error("beta low byte not taken");

  AST_WR_BETA_HI: assert property (
    wr_stb && addr == 16'h0649 |=>
      {1'b0, p1_beta1_exp, p1_beta0_lin[16:15]} == ($past(wdata) & 8'h7f))
    else $error("beta top byte not taken");

  AST_WR_GAMMA_HI: assert property (
    wr_stb && addr == 16'h064c |=>
      {2'b00, p1_gamma1_exp, p1_gamma0_lin[16]} == ($past(wdata) & 8'h3f))
    else $error("gamma top byte not taken");

  AST_WR_DELTA_MID: assert property (
    wr_stb && addr == 16'h064e |=>
      {p1_delta1_exp[0], p1_delta0_lin[14:8]} == $past(wdata))
    else $error("delta middle byte not taken");

  AST_WR_EXP_TOP: assert property (
    wr_stb && addr == 16'h064f |=>
      {p1_alpha3_exp, p1_delta1_exp[4:1]} == $past(wdata))
    else $error("shared exponent byte not taken");

  AST_WR_RDIV_LO: assert property (
    wr_stb && addr == 16'h0650 |=> p1_rdiv[7:0] == $past(wdata))
    else $error("divider low byte not taken");

  AST_WR_RDIV_HI: assert property (
    wr_stb && addr == 16'h0653 |=>
      {2'b00, p1_rdiv[29:24]} == ($past(wdata) & 8'h3f))
    else $error("divider top byte not taken");

endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the reference profile register bank
// assumes the bank answers a read one cycle late and never stalls
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dprf_pkg::*;
();
  ////////////////////////////////////////////////////////////////////////////
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic p0_phase_scale = 1'b0;
  logic p1_ref_active = 1'b0;
  logic [7:0] rdata, p0_phase_fill, p0_phase_drain, p0_freq_fill, p0_freq_drain;
  logic [9:0] p0_frac_v, p0_frac_u;
  logic [15:0] p0_phase_thr, p1_valid_timer, p1_redet_timer, p1_alpha0_lin;
  logic [25:0] p0_phase_thr_ps;
  logic [23:0] p0_freq_thr;
  logic p1_phase_scale, p1_prio_err;
  logic [2:0] p1_sel_prio, p1_prom_prio, p1_eff_prio, p1_alpha2_exp;
  logic [39:0] p1_ref_period;
  logic [19:0] p1_inner_tol, p1_outer_tol;
  logic [5:0] p1_alpha1_exp;
  logic [3:0] p1_alpha3_exp;
  logic [16:0] p1_beta0_lin, p1_gamma0_lin;
  logic [4:0] p1_beta1_exp, p1_gamma1_exp, p1_delta1_exp;
  logic [14:0] p1_delta0_lin;
  logic [29:0] p1_rdiv;
  logic [30:0] p1_rdiv_ratio;
  int errors = 0;
  int checked = 0;
  logic [31:0] seed = 32'h7b4ade48;
  dprf_byte_t m [16'h0626:16'h0653];

  always #10 mclk = ~mclk;

  dprf_regs_top dut (.mclk, .rst_b, .addr, .wdata, .wr_stb, .rd_stb, .rdata,
    .p0_phase_scale, .p1_ref_active, .p0_frac_v, .p0_frac_u, .p0_phase_thr,
    .p0_phase_thr_ps, .p0_phase_fill, .p0_phase_drain, .p0_freq_thr,
    .p0_freq_fill, .p0_freq_drain, .p1_phase_scale, .p1_sel_prio,
    .p1_prom_prio, .p1_eff_prio, .p1_prio_err, .p1_ref_period, .p1_inner_tol,
    .p1_outer_tol, .p1_valid_timer, .p1_redet_timer, .p1_alpha0_lin,
    .p1_alpha1_exp, .p1_alpha2_exp, .p1_alpha3_exp, .p1_beta0_lin,
    .p1_beta1_exp, .p1_gamma0_lin, .p1_gamma1_exp, .p1_delta0_lin,
    .p1_delta1_exp, .p1_rdiv, .p1_rdiv_ratio);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // writable bits of each byte; zero outside the bank and on the pad bytes
  function automatic logic [7:0] msk(input logic [15:0] a);
    case (a)
      16'h0627: return 8'hf3;
      16'h0632: return 8'hbf;
      16'h0638, 16'h0639: return 8'h00;
      16'h063c, 16'h063f: return 8'h0f;
      16'h0649: return 8'h7f;
      16'h0628, 16'h064c, 16'h0653: return 8'h3f;
      default: return (a >= 16'h0626 && a <= 16'h0653) ? 8'hff : 8'h00;
    endcase
  endfunction

  // random bytes kept within what software may write
  function automatic logic [7:0] legal(input logic [15:0] a,
                                       input logic [7:0] v);
    if (a == 16'h0638 || a == 16'h0639) v = 8'h00;
    if (a == 16'h0632 && v[5:3] > v[2:0]) v[5:3] = v[2:0];
    return v;
  endfunction

  function automatic logic [3:0] stat();
    logic [2:0] sel;
    logic [2:0] prom;
    sel = m['h632][2:0];
    prom = m['h632][5:3];
    return {p1_ref_active ? prom : sel, prom > sel};
  endfunction

  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    if (a == 16'h067e) return {4'h0, stat()};
    return (msk(a) != 8'h00) ? m[a] : 8'h00;
  endfunction

  task automatic chk(input string nm, input logic [39:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // strobes drop at the taking edge, so each wr or rd access leaves a one-cycle gap
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    if (msk(a) != 8'h00) m[a] = d & msk(a);
  endtask

  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata", rdata, exp_byte(a));
  endtask

  // write then read the same byte with no gap between the strobes
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b1;
    if (msk(a) != 8'h00) m[a] = d & msk(a);
    @(posedge mclk);
    rd_stb <= 1'b0;
    #1;
    chk("rdata_b2b", rdata, exp_byte(a));
  endtask

  task automatic rd_all();
    for (int a = 16'h0622; a <= 16'h0656; a++) rd(a[15:0]);
    rd(16'h067e);
  endtask

  task automatic fields();
    logic [29:0] r;
    logic [15:0] t;
    r = {m['h653][5:0], m['h652], m['h651], m['h650]};
    t = {m['h62a], m['h629]};
    @(posedge mclk);
    #1;
    chk("frac_v", p0_frac_v, {m['h627][1:0], m['h626]});
    chk("frac_u", p0_frac_u, {m['h628][5:0], m['h627][7:4]});
    chk("ph_thr", p0_phase_thr, t);
    chk("ph_ps", p0_phase_thr_ps, p0_phase_scale ? t * 26'd1000 : t);
    chk("ph_rate", {p0_phase_fill, p0_phase_drain}, {m['h62b], m['h62c]});
    chk("fq_thr", p0_freq_thr, {m['h62f], m['h62e], m['h62d]});
    chk("fq_rate", {p0_freq_fill, p0_freq_drain}, {m['h630], m['h631]});
    chk("scale", p1_phase_scale, m['h632][7]);
    chk("prio", {p1_prom_prio, p1_sel_prio}, m['h632][5:0]);
    chk("eff", {p1_eff_prio, p1_prio_err}, stat());
    chk("period", p1_ref_period, {m['h637], m['h636], m['h635], m['h634],
      m['h633]});
    chk("tol", {p1_inner_tol, p1_outer_tol}, {m['h63c][3:0], m['h63b],
      m['h63a], m['h63f][3:0], m['h63e], m['h63d]});
    chk("timers", {p1_valid_timer, p1_redet_timer}, {m['h641], m['h640],
      m['h643], m['h642]});
    chk("alpha", {p1_alpha0_lin, p1_alpha1_exp, p1_alpha2_exp, p1_alpha3_exp},
      {m['h645], m['h644], m['h646][5:0], m['h647][0], m['h646][7:6],
      m['h64f][7:4]});
    chk("beta", {p1_beta0_lin, p1_beta1_exp}, {m['h649][1:0], m['h648],
      m['h647][7:1], m['h649][6:2]});
    chk("gamma", {p1_gamma0_lin, p1_gamma1_exp}, {m['h64c][0], m['h64b],
      m['h64a], m['h64c][5:1]});
    chk("delta", {p1_delta0_lin, p1_delta1_exp}, {m['h64e][6:0], m['h64d],
      m['h64f][3:0], m['h64e][7]});
    chk("rdiv", p1_rdiv, r);
    chk("ratio", p1_rdiv_ratio, {1'b0, r} + 31'd1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge mclk);
    errors++;
    end_sim();
  end

  initial begin
    logic [31:0] v;
    logic [7:0] pv [3];
    logic [15:0] ra;
    pv = '{8'hff, 8'h38, 8'h07};
    for (int a = 16'h0626; a <= 16'h0653; a++) m[a] = 8'h00;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    rd_all();
    fields();
    @(posedge mclk);
    #1;
    chk("rdata_idle", rdata, 8'h00);
    $display("test reset done");
    repeat (3) begin
      v = nxt();
      @(posedge mclk);
      p0_phase_scale <= v[0];
      p1_ref_active <= v[1];
      // pad bytes, neighbours outside the bank and status are all hit
      for (int a = 16'h0622; a <= 16'h0656; a++) begin
        v = nxt();
        wr(a[15:0], legal(a[15:0], v[7:0]));
      end
      wr(16'h067e, 8'hff);
      fields();
      rd_all();
    end
    $display("test random fill done");
    for (int i = 0; i < 40; i++) begin
      v = nxt();
      ra = 16'h0626 + {10'h000, v[13:8]};
      wr_rd(ra, legal(ra, v[7:0]));
    end
    fields();
    $display("test back to back done");
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      p1_ref_active <= i[0];
      p0_phase_scale <= i[0];
      wr(16'h0629, 8'hff);
      wr(16'h062a, 8'hff);
      wr(16'h0632, pv[i / 2]);
      fields();
      rd(16'h067e);
    end
    $display("test priorities done");
    for (int a = 16'h0650; a <= 16'h0653; a++) wr(a[15:0], 8'hff);
    fields();
    $display("test divider done");
    end_sim();
  end
endmodule
`default_nettype wire
